// file: piqp_pkg.sv
// constants for the parallel i/q sample port
package piqp_pkg;

    // sample word width on each of the i and q line groups
    localparam int SMP_W = 16;

    // clocks-per-sample selection codes
    localparam logic [1:0] CPS_SEL_ONE = 2'h0;
    localparam logic [1:0] CPS_SEL_TWO = 2'h1;
    localparam logic [1:0] CPS_SEL_FOUR = 2'h2;

    // clocks-per-sample values held in the port state
    localparam logic [2:0] CPS_ONE = 3'h1;
    localparam logic [2:0] CPS_TWO = 3'h2;
    localparam logic [2:0] CPS_FOUR = 3'h4;
    localparam logic [2:0] CPS_RST = CPS_ONE;

    // first phase of the second sample in interleaved mode
    localparam logic [1:0] HALF_TWO = 2'h1;
    localparam logic [1:0] HALF_FOUR = 2'h2;

    // clock source selection codes
    localparam logic [1:0] SRC_INT = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;
    localparam logic [1:0] SRC_DEV = 2'h2;

    // internal clock divider width, unit step and reset value
    localparam int DIV_W = 8;
    localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
    localparam logic [DIV_W-1:0] DIV_RST = 8'h00;

endpackage

// file: piqp_clk_sel.sv
// port clock source selection and edge pulse generation
`timescale 1ns/1ps
module piqp_clk_sel
    import piqp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // configuration
    input wire logic [1:0] src_i,
    input wire logic [DIV_W-1:0] int_half_i,
    // candidate clock pins
    input wire logic ext_clk_i,
    input wire logic dev_clk_i,
    // selected port clock and its edges
    output logic pclk_o,
    output logic rise_o,
    output logic fall_o
);

    // all state of the selector
    typedef struct packed {
        logic [DIV_W-1:0] div_cnt; // internal divider count
        logic int_clk; // internally generated clock level
        logic pclk; // selected clock level
        logic rise; // pulse with the rising level
        logic fall; // pulse with the falling level
    } piqp_cs_t;

    piqp_cs_t cs_r; // registered state
    piqp_cs_t cs_nxt; // next state
    logic [DIV_W-1:0] half_w; // half period, zero treated as one
    logic sel_w; // currently selected source level

    // divider, source mux and edge detection
    always_comb begin
        cs_nxt = cs_r;
        half_w = (int_half_i == DIV_RST) ? DIV_ONE : int_half_i;
        // internal source toggles every half period
        if (cs_r.div_cnt >= half_w - DIV_ONE) begin
            cs_nxt.div_cnt = DIV_RST;
            cs_nxt.int_clk = ~cs_r.int_clk;
        end else begin
            cs_nxt.div_cnt = cs_r.div_cnt + DIV_ONE;
        end
        // one of three sources feeds the port clock
        unique case (src_i)
            SRC_EXT: sel_w = ext_clk_i;
            SRC_DEV: sel_w = dev_clk_i;
            default: sel_w = cs_r.int_clk;
        endcase
        cs_nxt.pclk = sel_w;
        cs_nxt.rise = sel_w & ~cs_r.pclk;
        cs_nxt.fall = ~sel_w & cs_r.pclk;
    end

    // state register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_r <= '0;
        end else begin
            cs_r <= cs_nxt;
        end
    end

    assign pclk_o = cs_r.pclk;
    assign rise_o = cs_r.rise;
    assign fall_o = cs_r.fall;

    // external pin reaches the port clock in one cycle
    ext_follow_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (src_i == SRC_EXT && $stable(src_i)) |=> (pclk_o == $past(ext_clk_i)))
        else $error("port clock does not follow external clock");

    // rise pulse marks a real rising level
    rise_edge_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rise_o |-> (pclk_o && !$past(pclk_o)))
        else $error("rise pulse without rising port clock");

endmodule // piqp_clk_sel

// file: piqp_port.sv
// parallel and interleaved i/q sample port, output and input directions
`timescale 1ns/1ps
module piqp_port
    import piqp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // configuration levels
    input wire logic [1:0] cps_sel_i,
    input wire logic ilv_en_i,
    input wire logic ilv_qi_i,
    input wire logic sig_if_i,
    input wire logic dir_in_i,
    input wire logic [1:0] clk_src_i,
    input wire logic [DIV_W-1:0] int_half_i,
    // clock pins
    input wire logic ext_clk_i,
    input wire logic dev_clk_i,
    output logic port_clk_o,
    output logic dev_clk_o,
    // generator side samples
    input wire logic smp_valid_i,
    output logic smp_ready_o,
    input wire logic [SMP_W-1:0] smp_i_i,
    input wire logic [SMP_W-1:0] smp_q_i,
    output logic underrun_o,
    // captured samples in input direction
    output logic cap_valid_o,
    output logic [SMP_W-1:0] cap_i_o,
    output logic [SMP_W-1:0] cap_q_o,
    // i data lines, two-way
    input wire logic [SMP_W-1:0] io_i_in_i,
    output logic [SMP_W-1:0] io_i_out_o,
    output logic io_i_oen_o,
    // q data lines, two-way
    input wire logic [SMP_W-1:0] io_q_in_i,
    output logic [SMP_W-1:0] io_q_out_o,
    output logic io_q_oen_o
);

    // all state of the port
    typedef struct packed {
        logic [1:0] cnt; // port clock rises within the sample period
        logic [2:0] cps; // active clocks per sample
        logic ilv; // active interleave enable
        logic qi; // active order, q first when set
        logic dir_in; // active direction, input when set
        logic [SMP_W-1:0] hold_i; // current i sample
        logic [SMP_W-1:0] hold_q; // current q sample
        logic [SMP_W-1:0] out_i; // i line drive
        logic [SMP_W-1:0] out_q; // q line drive
        logic [SMP_W-1:0] cap_i; // captured i sample
        logic [SMP_W-1:0] cap_q; // captured q sample
        logic cap_v; // capture complete pulse
        logic udr; // no sample at a boundary pulse
    } piqp_st_t;

    piqp_st_t st_r; // registered state
    piqp_st_t st_nxt; // next state

    logic pclk_w; // selected port clock level
    logic rise_w; // port clock rising pulse
    logic fall_w; // port clock falling pulse
    logic bnd_w; // sample period boundary
    logic [2:0] c_cps; // requested clocks per sample
    logic [2:0] e_cps; // clocks per sample in force this rise
    logic e_ilv; // interleave in force this rise
    logic e_qi; // order in force this rise
    logic e_dir; // direction in force this rise
    logic [2:0] nc_w; // incremented phase count
    logic [SMP_W-1:0] hi_w; // i sample of this period
    logic [SMP_W-1:0] hq_w; // q sample of this period
    logic second_w; // current phase carries the second sample

    // map the selection code to clocks per sample
    function automatic logic [2:0] cps_dec(input logic [1:0] sel);
        unique case (sel)
            CPS_SEL_TWO: cps_dec = CPS_TWO;
            CPS_SEL_FOUR: cps_dec = CPS_FOUR;
            default: cps_dec = CPS_ONE; // one and the spare code
        endcase
    endfunction

    // second-sample decision for a given phase and rate
    function automatic logic is_second(input logic [2:0] cps, input logic [1:0] cnt);
        unique case (cps)
            CPS_TWO: is_second = (cnt >= HALF_TWO);
            CPS_FOUR: is_second = (cnt >= HALF_FOUR);
            default: is_second = 1'b0; // one-clock waits for the fall
        endcase
    endfunction

    // port clock source and edge pulses
    piqp_clk_sel u_clk_sel (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .src_i(clk_src_i),
        .int_half_i(int_half_i),
        .ext_clk_i(ext_clk_i),
        .dev_clk_i(dev_clk_i),
        .pclk_o(pclk_w),
        .rise_o(rise_w),
        .fall_o(fall_w)
    );

    // requested settings and the boundary of a sample period
    always_comb begin
        // IF type and input direction pin the rate at one
        if (sig_if_i || dir_in_i) begin
            c_cps = CPS_ONE;
        end else begin
            c_cps = cps_dec(cps_sel_i);
        end
        bnd_w = rise_w && (st_r.cnt == 2'h0);
        // new settings only at a boundary
        e_cps = bnd_w ? c_cps : st_r.cps;
        e_ilv = bnd_w ? ilv_en_i : st_r.ilv;
        e_qi = bnd_w ? ilv_qi_i : st_r.qi;
        e_dir = bnd_w ? dir_in_i : st_r.dir_in;
    end

    // next state of the whole port
    always_comb begin
        st_nxt = st_r;
        st_nxt.cap_v = 1'b0;
        st_nxt.udr = 1'b0;
        nc_w = {1'b0, st_r.cnt} + 3'h1;
        hi_w = st_r.hold_i;
        hq_w = st_r.hold_q;
        second_w = 1'b0;
        if (bnd_w) begin
            st_nxt.cps = e_cps;
            st_nxt.ilv = e_ilv;
            st_nxt.qi = e_qi;
            st_nxt.dir_in = e_dir;
        end
        if (rise_w) begin
            // phase wraps after the active number of clocks
            st_nxt.cnt = (nc_w >= e_cps) ? 2'h0 : nc_w[1:0];
            if (!e_dir) begin
                // one fresh i and q pair per period
                if (bnd_w) begin
                    if (smp_valid_i) begin
                        hi_w = smp_i_i;
                        hq_w = smp_q_i;
                    end else begin
                        st_nxt.udr = 1'b1; // repeat the previous pair
                    end
                end
                st_nxt.hold_i = hi_w;
                st_nxt.hold_q = hq_w;
                if (!e_ilv) begin
                    // both groups hold across the extra clocks
                    st_nxt.out_i = hi_w;
                    st_nxt.out_q = hq_w;
                end else begin
                    // only the i lines carry data
                    st_nxt.out_q = '0;
                    second_w = is_second(e_cps, st_r.cnt);
                    // order picks which sample leads
                    st_nxt.out_i = (second_w ^ e_qi) ? hq_w : hi_w;
                end
            end else begin
                // input: rate one, capture on the rise
                if (e_ilv) begin
                    if (e_qi) begin
                        st_nxt.cap_q = io_i_in_i;
                    end else begin
                        st_nxt.cap_i = io_i_in_i;
                    end
                end else begin
                    st_nxt.cap_i = io_i_in_i;
                    st_nxt.cap_q = io_q_in_i;
                    st_nxt.cap_v = 1'b1;
                end
            end
        end else if (fall_w && st_r.ilv && (st_r.cps == CPS_ONE)) begin
            if (!st_r.dir_in) begin
                // second sample on the opposite transition
                st_nxt.out_i = st_r.qi ? st_r.hold_i : st_r.hold_q;
            end else begin
                // input interleaved: second sample on the fall
                if (st_r.qi) begin
                    st_nxt.cap_i = io_i_in_i;
                end else begin
                    st_nxt.cap_q = io_i_in_i;
                end
                st_nxt.cap_v = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= '{cps: CPS_RST, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // selected clock to both clock pins
    assign port_clk_o = pclk_w;
    assign dev_clk_o = pclk_w;

    // a pair is taken only at an output boundary
    assign smp_ready_o = bnd_w && !dir_in_i;
    assign underrun_o = st_r.udr;

    // captured samples
    assign cap_valid_o = st_r.cap_v;
    assign cap_i_o = st_r.cap_i;
    assign cap_q_o = st_r.cap_q;

    // line drive, released in input direction
    assign io_i_out_o = st_r.out_i;
    assign io_q_out_o = st_r.out_q;
    assign io_i_oen_o = st_r.dir_in;
    assign io_q_oen_o = st_r.dir_in;

    // active rate is always one of the three values
    cps_legal_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (st_r.cps == CPS_ONE) || (st_r.cps == CPS_TWO) || (st_r.cps == CPS_FOUR))
        else $error("illegal clocks per sample in force");

    // non-interleaved lines hold within a period
    hold_stable_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (rise_w && st_r.cnt != 2'h0 && !st_r.ilv && !st_r.dir_in)
        |=> ($stable(io_i_out_o) && $stable(io_q_out_o)))
        else $error("sample changed inside its period");

    // a new pair enters only at phase zero
    one_pair_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (rise_w && st_r.cnt != 2'h0) |=> ($stable(st_r.hold_i) && $stable(st_r.hold_q)))
        else $error("sample taken inside a period");

    // IF type pins the rate at one
    if_rate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (bnd_w && sig_if_i) |=> (st_r.cps == CPS_ONE))
        else $error("IF type did not force one clock per sample");

    // input direction pins the rate at one
    in_rate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (bnd_w && dir_in_i) |=> (st_r.cps == CPS_ONE && st_r.dir_in))
        else $error("input direction did not force one clock per sample");

    // leading sample follows the order setting
    lead_order_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (bnd_w && ilv_en_i && !dir_in_i)
        |=> (io_i_out_o == (st_r.qi ? st_r.hold_q : st_r.hold_i)))
        else $error("wrong leading sample for interleave order");

    // q lines idle while interleaving
    q_quiet_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (st_r.ilv && !st_r.dir_in && $past(rise_w)) |-> (io_q_out_o == '0))
        else $error("q lines driven while interleaved");

    // one-clock interleave: second sample after the fall
    fall_second_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (fall_w && st_r.ilv && st_r.cps == CPS_ONE && !st_r.dir_in)
        |=> (io_i_out_o == (st_r.qi ? st_r.hold_i : st_r.hold_q)))
        else $error("second interleaved sample missing on fall");

    // two-clock interleave: second sample in second period
    two_second_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (rise_w && st_r.ilv && st_r.cps == CPS_TWO && st_r.cnt == 2'h1 && !st_r.dir_in)
        |=> (io_i_out_o == (st_r.qi ? st_r.hold_i : st_r.hold_q)))
        else $error("second sample not in second clock period");

    // four-clock interleave: first sample through phase one
    four_first_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (rise_w && st_r.ilv && st_r.cps == CPS_FOUR && st_r.cnt == 2'h1 && !st_r.dir_in)
        |=> (io_i_out_o == (st_r.qi ? st_r.hold_q : st_r.hold_i)))
        else $error("first sample not held for two clock periods");

    // settings stay put between boundaries
    cfg_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !bnd_w |=> ($stable(st_r.cps) && $stable(st_r.ilv) && $stable(st_r.qi)))
        else $error("setting changed inside a sample period");

    // a taken pair lands in the hold registers
    pair_load_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (smp_ready_o && smp_valid_i)
        |=> (st_r.hold_i == $past(smp_i_i) && st_r.hold_q == $past(smp_q_i)))
        else $error("offered pair not loaded at the boundary");

    // missing pair repeats the previous one and is flagged
    underrun_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (smp_ready_o && !smp_valid_i)
        |=> (underrun_o && $stable(st_r.hold_i) && $stable(st_r.hold_q)))
        else $error("missing pair not flagged or not repeated");

    // four-clock interleave: second sample through phase three
    four_second_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (rise_w && st_r.ilv && st_r.cps == CPS_FOUR && st_r.cnt == 2'h3 && !st_r.dir_in)
        |=> (io_i_out_o == (st_r.qi ? st_r.hold_i : st_r.hold_q)))
        else $error("second sample not held for two clock periods");

    // input direction: both line groups captured on a rise
    in_capture_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (rise_w && st_r.dir_in && dir_in_i && !st_r.ilv && !ilv_en_i)
        |=> (cap_valid_o && cap_i_o == $past(io_i_in_i) && cap_q_o == $past(io_q_in_i)))
        else $error("input pair not captured on the rise");

    // input interleaved: pair completes on the fall
    in_fall_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (fall_w && st_r.dir_in && st_r.ilv && st_r.cps == CPS_ONE)
        |=> (cap_valid_o && (st_r.qi ? cap_i_o : cap_q_o) == $past(io_i_in_i)))
        else $error("second interleaved input sample not captured on fall");

endmodule // piqp_port

// file: piqp_dut_model.sv
// behavioural receiving device: logs line values, drives lines in input direction
`timescale 1ns/1ps
module piqp_dut_model
    import piqp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // port clock and interleave setup
    input wire logic port_clk_i,
    input wire logic ilv_i,
    input wire logic qi_i,
    // lines as seen on the wire
    input wire logic [SMP_W-1:0] line_i_i,
    input wire logic [SMP_W-1:0] line_q_i,
    // drive toward the port and own clock
    output logic [SMP_W-1:0] drv_i_o,
    output logic [SMP_W-1:0] drv_q_o,
    output logic dev_clk_o
);
    logic [31:0] log_v[$]; // line values, i lines in upper half
    int log_n[$]; // clk_i cycles each value stood
    logic [31:0] cur = 32'h0; // value now on the lines
    int cnt = 0; // cycles the current value has stood
    logic pc_q, r1, r2, f1, f2; // port clock edge pipeline
    logic [11:0] k; // sample counter
    int dc; // device clock divider

    // logs every change on the lines with how long the old value stood
    always @(posedge clk_i) begin
        if ({line_i_i, line_q_i} !== cur) begin
            log_v.push_back(cur);
            log_n.push_back(cnt);
            cur <= {line_i_i, line_q_i};
            cnt <= 1;
        end else begin
            cnt <= cnt + 1;
        end
    end

    // free device clock and sample drive three cycles after port clock edges
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {pc_q, r1, r2, f1, f2, dev_clk_o} <= 6'h00;
            k <= 12'h000;
            dc <= 0;
            drv_i_o <= 16'h0000;
            drv_q_o <= 16'hFFFF;
        end else begin
            pc_q <= port_clk_i;
            r1 <= port_clk_i & ~pc_q;
            r2 <= r1;
            f1 <= ~port_clk_i & pc_q;
            f2 <= f1;
            dc <= (dc == 4) ? 0 : dc + 1;
            if (dc == 4) begin // period of ten clk_i cycles
                dev_clk_o <= ~dev_clk_o;
            end
            if (f2) begin // leading value, stable at the rise
                drv_i_o <= (ilv_i && qi_i) ? {4'h4, k} : {4'h3, k};
                drv_q_o <= ilv_i ? ~drv_q_o : {4'h4, k};
            end else if (r2 && ilv_i) begin // other value, stable at the fall
                drv_i_o <= qi_i ? {4'h3, k} : {4'h4, k};
                drv_q_o <= ~drv_q_o;
            end
            if (r2) begin
                k <= k + 12'h001;
            end
        end
    end
endmodule // piqp_dut_model

// file: piqp_port_tb_top.sv
// self-checking bench for the parallel i/q sample port
`timescale 1ns/1ps
module piqp_port_tb_top import piqp_pkg::*;;
    logic clk_i = 1'b0; // system clock
    logic rstn_i = 1'b0; // active low reset
    logic [1:0] cps_sel_i = CPS_SEL_ONE, clk_src_i = SRC_INT; // setup codes
    logic ilv_en_i = 0, ilv_qi_i = 0, sig_if_i = 0, dir_in_i = 0, ext_clk_i = 0; // setup bits
    logic [DIV_W-1:0] int_half_i = 8'h02; // internal half period set by the system
    int idx = 0, lim = 0, ec = 0, cyc = 0, num_errors = 0, comparisons = 0; // counters
    logic mon_en = 0, src_d = 0; // clock follow monitor
    logic smp_valid_i, port_clk_o, dev_clk_o, smp_ready_o, underrun_o, cap_valid_o, dev_clk_m;
    logic io_i_oen_o, io_q_oen_o; // line enables, low drives
    logic [SMP_W-1:0] smp_i_i, smp_q_i, cap_i_o, cap_q_o, io_i_out_o, io_q_out_o;
    logic [SMP_W-1:0] io_i_in_i, io_q_in_i, drv_i, drv_q; // resolved and model lines
    logic [31:0] caps[$]; // captured pairs
    int cap_t[$]; // cycle of each capture

    // generator feed of numbered pairs
    assign smp_valid_i = idx < lim;
    assign smp_i_i = {4'h1, idx[11:0]};
    assign smp_q_i = {4'h2, idx[11:0]};
    // wire level from whoever drives
    assign io_i_in_i = io_i_oen_o ? drv_i : io_i_out_o;
    assign io_q_in_i = io_q_oen_o ? drv_q : io_q_out_o;

    always #20 clk_i = ~clk_i;

    // feed advance, external clock of period six, capture log
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (smp_valid_i && smp_ready_o) idx <= idx + 1;
        ec <= (ec == 2) ? 0 : ec + 1;
        if (ec == 2) ext_clk_i <= ~ext_clk_i;
        src_d <= (clk_src_i == SRC_EXT) ? ext_clk_i : dev_clk_m;
        if (cap_valid_o === 1'b1) begin
            caps.push_back({cap_i_o, cap_q_o});
            cap_t.push_back(cyc);
        end
    end

    // port clock follows the chosen source on both outputs
    always @(negedge clk_i) begin
        if (mon_en) begin
            chk(src_d, port_clk_o);
            chk(port_clk_o, dev_clk_o);
        end
    end

    piqp_port piqp_port_i (.clk_i(clk_i), .rstn_i(rstn_i), .cps_sel_i(cps_sel_i),
        .ilv_en_i(ilv_en_i), .ilv_qi_i(ilv_qi_i), .sig_if_i(sig_if_i), .dir_in_i(dir_in_i),
        .clk_src_i(clk_src_i), .int_half_i(int_half_i), .ext_clk_i(ext_clk_i),
        .dev_clk_i(dev_clk_m), .port_clk_o(port_clk_o), .dev_clk_o(dev_clk_o),
        .smp_valid_i(smp_valid_i), .smp_ready_o(smp_ready_o), .smp_i_i(smp_i_i),
        .smp_q_i(smp_q_i), .underrun_o(underrun_o), .cap_valid_o(cap_valid_o),
        .cap_i_o(cap_i_o), .cap_q_o(cap_q_o), .io_i_in_i(io_i_in_i), .io_i_out_o(io_i_out_o),
        .io_i_oen_o(io_i_oen_o), .io_q_in_i(io_q_in_i), .io_q_out_o(io_q_out_o),
        .io_q_oen_o(io_q_oen_o));

    piqp_dut_model piqp_dut_model_i (.clk_i(clk_i), .rstn_i(rstn_i), .port_clk_i(port_clk_o),
        .ilv_i(ilv_en_i), .qi_i(ilv_qi_i), .line_i_i(io_i_in_i), .line_q_i(io_q_in_i),
        .drv_i_o(drv_i), .drv_q_o(drv_q), .dev_clk_o(dev_clk_m));

    // one comparison, counted
    task chk(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // output run: feed sixteen pairs, then check stand times and pairing
    task run(input logic [1:0] cs, src, input logic il, qi, sif, input int da, db, mid);
        int w;
        int j;
        logic [31:0] v;
        logic [11:0] lk;
        @(posedge clk_i);
        {cps_sel_i, clk_src_i, ilv_en_i, ilv_qi_i, sig_if_i, dir_in_i} <= {cs, src, il, qi, sif, 1'b0};
        repeat (40) @(posedge clk_i);
        mon_en <= (src != SRC_INT);
        piqp_dut_model_i.log_v.delete();
        piqp_dut_model_i.log_n.delete();
        lim <= idx + 16;
        @(posedge clk_i);
        for (w = 0; w < 3000 && idx < lim; w++) begin
            if (w == mid) cps_sel_i <= CPS_SEL_ONE; // mid-period change
            @(posedge clk_i);
        end
        chk(lim, idx);
        for (w = 0; w < 200 && underrun_o !== 1'b1; w++) @(negedge clk_i);
        chk(1, underrun_o);
        lk = 12'(lim - 1);
        chk(0, io_i_oen_o);
        if (!il) chk({4'h1, lk, 4'h2, lk}, piqp_dut_model_i.cur);
        for (j = 3; j < piqp_dut_model_i.log_v.size() - 3; j++) begin
            v = piqp_dut_model_i.log_v[j];
            w = piqp_dut_model_i.log_n[j];
            chk(1, w == da || w == db);
            if (!il) chk({4'h2, v[27:16]}, v[15:0]);
            else begin
                chk(0, v[15:0]);
                if (v[31:28] == (qi ? 4'h2 : 4'h1))
                    chk({(qi ? 4'h1 : 4'h2), v[27:16]}, piqp_dut_model_i.log_v[j+1][31:16]);
            end
        end
        mon_en <= 0;
        $display("test done: out cps=%h src=%h ilv=%b qi=%b", cs, src, il, qi);
    endtask

    // input run: captures at one per port period with the four-clock cps code set
    task run_in(input logic il, qi);
        int j;
        @(posedge clk_i);
        {dir_in_i, cps_sel_i, ilv_en_i, ilv_qi_i} <= {1'b1, CPS_SEL_FOUR, il, qi};
        clk_src_i <= SRC_INT; // internal clock sets the capture period
        int_half_i <= 8'h04;
        repeat (60) @(posedge clk_i);
        caps.delete();
        cap_t.delete();
        repeat (120) @(posedge clk_i);
        chk(1, io_i_oen_o);
        chk(1, caps.size() > 10);
        for (j = 2; j < caps.size(); j++) begin
            chk({4'h4, caps[j][27:16]}, caps[j][15:0]);
            chk(caps[j-1][27:16] + 12'h001, caps[j][27:16]);
            chk(8, cap_t[j] - cap_t[j-1]);
        end
        dir_in_i <= 0;
        int_half_i <= 8'h02;
        $display("test done: in ilv=%b qi=%b", il, qi);
    endtask

    // counts and verdict
    task close_out;
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog well past the expected run length
    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        close_out;
    end

    // main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        run(CPS_SEL_ONE, SRC_INT, 0, 0, 0, 4, 4, -1);
        run(CPS_SEL_TWO, SRC_INT, 0, 0, 0, 8, 8, -1);
        run(CPS_SEL_FOUR, SRC_INT, 0, 0, 0, 16, 16, -1);
        run(CPS_SEL_FOUR, SRC_INT, 0, 0, 1, 4, 4, -1);
        run(CPS_SEL_ONE, SRC_INT, 1, 0, 0, 2, 2, -1);
        run(CPS_SEL_TWO, SRC_INT, 1, 1, 0, 4, 4, -1);
        run(CPS_SEL_FOUR, SRC_INT, 1, 0, 0, 8, 8, -1);
        run(CPS_SEL_FOUR, SRC_INT, 1, 1, 0, 8, 8, -1);
        run(CPS_SEL_FOUR, SRC_INT, 0, 0, 0, 16, 4, 70);
        run(CPS_SEL_TWO, SRC_EXT, 0, 0, 0, 12, 12, -1);
        run(CPS_SEL_ONE, SRC_DEV, 1, 0, 0, 5, 5, -1);
        run_in(0, 0);
        run_in(1, 0);
        run_in(1, 1);
        close_out;
    end
endmodule // piqp_port_tb_top
